// ===== tile_regs_pkg.sv
// constants, field layouts and carriers of the tile control and status bank
package tile_regs_pkg;

   // register numbers as seen by the status read and write instructions
   localparam logic [7:0]  OFS_FEATURE     = 8'h02;
   localparam logic [7:0]  OFS_BOOT        = 8'h03;
   localparam logic [7:0]  OFS_SECURITY    = 8'h05;
   localparam logic [7:0]  OFS_OSC_CTRL    = 8'h06;
   localparam logic [7:0]  OFS_OSC_COUNT0  = 8'h07;

   // tile_feature_control fields
   localparam int          TX_DELAY_LSB    = 18;
   localparam int          TX_DELAY_MSB    = 25;
   localparam int          TX_DIV_LSB      = 9;
   localparam int          TX_DIV_MSB      = 17;
   localparam int          RGMII_EN_BIT    = 8;
   localparam int          DYN_MODE_BIT    = 5;
   localparam int          DIV_EN_BIT      = 4;
   localparam int          USB_MODE_BIT    = 2;
   localparam int          ULPI_EN_BIT     = 1;
   localparam logic [31:0] FEATURE_MASK    = 32'h03ff_ff36;
   localparam logic [31:0] FEATURE_RESET   = 32'h0000_0000;

   // tile_boot_state fields
   localparam int          PROC_NUM_LSB    = 16;
   localparam int          OVERRIDE_BIT    = 8;
   localparam int          CORE1_OFF_BIT   = 5;
   localparam int          OTP_POLL_BIT    = 4;
   localparam int          BOOT_RAM_BIT    = 3;
   localparam int          BOOT_JTAG_BIT   = 2;

   // tile_security_settings fields
   localparam int          SEC_LOCK_BIT    = 31;
   localparam int          SEC_GDEBUG_BIT  = 14;
   localparam int          SEC_MASTER_BIT  = 12;
   localparam int          SEC_SECTOR_LSB  = 8;
   localparam int          SEC_SECTOR_MSB  = 11;
   localparam int          SEC_REDUND_BIT  = 7;
   localparam int          SEC_IMAGE_BIT   = 5;
   localparam int          SEC_PLLJTAG_BIT = 4;
   localparam int          SEC_TAP_BIT     = 0;
   localparam logic [31:0] SEC_MASK        = 32'h8000_5fb1;
   localparam logic [31:0] SEC_RESET       = 32'h0000_0000;

   // ring_oscillator_control fields
   localparam int          OSC_CORE_BIT    = 1;
   localparam int          OSC_PERIPH_BIT  = 0;
   localparam logic [31:0] OSC_MASK        = 32'h0000_0003;
   localparam logic [31:0] OSC_RESET       = 32'h0000_0000;
   localparam int          OSC_NUM         = 4;
   localparam int          OSC_CNT_W       = 16;
   localparam logic [15:0] OSC_CNT_INIT    = 16'h0000;

   typedef struct packed {
      logic       tx_ctl;
      logic [3:0] txd;
   } rgmii_lane_t;

   typedef struct packed {
      logic       boot_override_flag;
      logic       second_core_power_flag;
      logic       otp_poll_off;
      logic       boot_from_ram;
      logic       boot_from_jtag;
      logic [1:0] pll_mode_pin_sample;
   } boot_straps_t;

endpackage

// ===== tile_control_status_regs.sv
// tile control, boot state, security and ring oscillator register bank
// Operation
// - tx data delayed by field 25:18 plus one cycles
// - tx clock high at divider, low at half
// - bit 8 enables rgmii ports
// - bit 5 divides only while threads paused
// - bit 4 enables low power clock divide
// - bit 2 picks utmi, clear picks ulpi
// - bit 1 enables ulpi support module
// - boot state read only, processor number
// - boot state shows pll pins, jtag, ram
// - boot state shows core1, otp poll, override
// - security register copies the otp word
// - security bit 31 removes write permission
// - security bits 0, 4, 14 block debug
// - security bits lock otp, redundancy, image boot
// - four ring oscillators clock four counters
// - control bit 1 core, bit 0 peripheral
// - oscillators asynchronous to the tile clock
// - counters read at four following registers
// - sixteen bit counters survive system reset
`timescale 1ns/1ps
module tile_control_status_regs #(
   parameter int DELAY_DEPTH = 256,    // tx delay line slots
   parameter int DIV_W       = 9       // tx clock divider width
) (
   input  wire logic                       ref_clk_in,                // tile core clock
   input  wire logic                       rst_in,                    // sync reset, high
   input  wire logic                       status_write_instr_in,     // write strobe
   input  wire logic                       status_read_instr_in,      // read strobe
   input  wire logic [7:0]                 ps_addr_in,                // register number
   input  wire logic [31:0]                ps_wdata_in,               // write data
   output logic [31:0]                     ps_rdata_out,              // read data
   output logic                            ps_rvalid_out,             // read data valid
   input  wire logic [7:0]                 processor_number_in,       // tile number
   input  wire tile_regs_pkg::boot_straps_t straps_in,                // boot pins
   input  wire logic                       otp_load_in,               // otp word valid
   input  wire logic [31:0]                otp_word_in,               // otp security word
   input  wire logic                       threads_paused_in,         // all threads paused
   input  wire tile_regs_pkg::rgmii_lane_t tx_lane_in,                // tx data in
   output tile_regs_pkg::rgmii_lane_t      tx_lane_out,               // delayed tx data
   output logic                            rgmii_tx_clk_out,          // divided tx clock
   output logic                            rgmii_port_enable_out,     // rgmii ports on
   output logic                            pll_divide_active_out,     // low power divide
   output logic                            usb_utmi_mode_out,         // 1 utmi, 0 ulpi
   output logic                            ulpi_support_enable_out,   // ulpi module on
   output logic                            jtag_tap_block_out,        // tap access blocked
   output logic                            pll_jtag_block_out,        // pll jtag blocked
   output logic                            global_debug_block_out,    // debug blocked
   output logic                            otp_master_lock_out,       // all sectors locked
   output logic [3:0]                      otp_sector_lock_out,       // per sector lock
   output logic                            otp_redundancy_enable_out, // otp redundancy
   output logic                            otp_image_boot_force_out,  // boot from otp
   input  wire logic [3:0]                 oscillator_tick_in,        // ring osc outputs
   output logic [3:0]                      oscillator_run_out         // ring osc enables
);

   localparam int PTR_W = $clog2(DELAY_DEPTH);

   // the delay and divider fields are 8 and 9 bits wide, so other sizes cannot be served
   if (DELAY_DEPTH != 256 || DIV_W != 9) begin
      $error("delay depth and divider width must match the 8 and 9 bit fields");
   end

   function automatic logic [31:0] masked(input logic [31:0] value, input logic [31:0] mask);
      masked = value & mask;
   endfunction

   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   // register file state
   logic [31:0]              feature_reg,   feature_next;
   logic [31:0]              security_reg,  security_next;
   logic [31:0]              osc_ctrl_reg,  osc_ctrl_next;
   tile_regs_pkg::boot_straps_t boot_reg,   boot_next;
   logic [31:0]              rdata_reg,     rdata_next;
   logic                     rvalid_reg,    rvalid_next;
   tile_regs_pkg::boot_straps_t strap_s1_reg, strap_s2_reg;
   logic [7:0]               tx_delay;
   logic [DIV_W-1:0]         tx_div;

   assign tx_delay = feature_reg[tile_regs_pkg::TX_DELAY_MSB:tile_regs_pkg::TX_DELAY_LSB];
   assign tx_div   = feature_reg[tile_regs_pkg::TX_DIV_MSB:tile_regs_pkg::TX_DIV_LSB];

   // oscillator counters, no reset so a reset does not wipe the entropy
   logic [tile_regs_pkg::OSC_CNT_W-1:0] osc_count_reg [tile_regs_pkg::OSC_NUM] =
      '{default: tile_regs_pkg::OSC_CNT_INIT};
   logic [tile_regs_pkg::OSC_CNT_W-1:0] osc_count_next [tile_regs_pkg::OSC_NUM];
   logic [3:0]               osc_s1_reg, osc_s2_reg, osc_s3_reg;
   logic [3:0]               osc_run_reg, osc_run_next;

   always_comb begin
      feature_next  = feature_reg;
      security_next = security_reg;
      osc_ctrl_next = osc_ctrl_reg;
      boot_next     = boot_reg;
      if (status_write_instr_in) begin
         if (hit(ps_addr_in, tile_regs_pkg::OFS_FEATURE)) begin
            feature_next = masked(ps_wdata_in, tile_regs_pkg::FEATURE_MASK);
         end else if (hit(ps_addr_in, tile_regs_pkg::OFS_SECURITY) &&
                      !security_reg[tile_regs_pkg::SEC_LOCK_BIT]) begin
            security_next = masked(ps_wdata_in, tile_regs_pkg::SEC_MASK);
         end else if (hit(ps_addr_in, tile_regs_pkg::OFS_OSC_CTRL)) begin
            osc_ctrl_next = masked(ps_wdata_in, tile_regs_pkg::OSC_MASK);
         end
      end
      // otp copy beats a software write in the same cycle
      if (otp_load_in) begin
         security_next = masked(otp_word_in, tile_regs_pkg::SEC_MASK);
      end
      // straps are taken while reset is held, then frozen
      if (rst_in) begin
         boot_next = strap_s2_reg;
      end
   end

   always_comb begin
      rdata_next  = 32'h0000_0000;
      rvalid_next = status_read_instr_in;
      if (!status_read_instr_in) begin
         rdata_next = 32'h0000_0000;
      end else if (hit(ps_addr_in, tile_regs_pkg::OFS_FEATURE)) begin
         rdata_next = feature_reg;
      end else if (hit(ps_addr_in, tile_regs_pkg::OFS_BOOT)) begin
         rdata_next[tile_regs_pkg::PROC_NUM_LSB +: 8] = processor_number_in;
         rdata_next[tile_regs_pkg::OVERRIDE_BIT]  = boot_reg.boot_override_flag;
         rdata_next[tile_regs_pkg::CORE1_OFF_BIT] = boot_reg.second_core_power_flag;
         rdata_next[tile_regs_pkg::OTP_POLL_BIT]  = boot_reg.otp_poll_off;
         rdata_next[tile_regs_pkg::BOOT_RAM_BIT]  = boot_reg.boot_from_ram;
         rdata_next[tile_regs_pkg::BOOT_JTAG_BIT] = boot_reg.boot_from_jtag;
         rdata_next[1:0] = boot_reg.pll_mode_pin_sample;
      end else if (hit(ps_addr_in, tile_regs_pkg::OFS_SECURITY)) begin
         rdata_next = security_reg;
      end else if (hit(ps_addr_in, tile_regs_pkg::OFS_OSC_CTRL)) begin
         rdata_next = osc_ctrl_reg;
      end else if (ps_addr_in >= tile_regs_pkg::OFS_OSC_COUNT0 &&
                   ps_addr_in <  tile_regs_pkg::OFS_OSC_COUNT0 + 8'h04) begin
         rdata_next[15:0] = osc_count_reg[2'(ps_addr_in - tile_regs_pkg::OFS_OSC_COUNT0)];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      strap_s1_reg <= straps_in;
      strap_s2_reg <= strap_s1_reg;
      boot_reg     <= boot_next;
      if (rst_in) begin
         feature_reg  <= tile_regs_pkg::FEATURE_RESET;
         security_reg <= tile_regs_pkg::SEC_RESET;
         osc_ctrl_reg <= tile_regs_pkg::OSC_RESET;
         rdata_reg    <= 32'h0000_0000;
         rvalid_reg   <= 1'b0;
      end else begin
         feature_reg  <= feature_next;
         security_reg <= security_next;
         osc_ctrl_reg <= osc_ctrl_next;
         rdata_reg    <= rdata_next;
         rvalid_reg   <= rvalid_next;
      end
   end

   assign ps_rdata_out              = rdata_reg;
   assign ps_rvalid_out             = rvalid_reg;
   assign rgmii_port_enable_out     = feature_reg[tile_regs_pkg::RGMII_EN_BIT];
   assign usb_utmi_mode_out         = feature_reg[tile_regs_pkg::USB_MODE_BIT];
   assign ulpi_support_enable_out   = feature_reg[tile_regs_pkg::ULPI_EN_BIT];
   assign jtag_tap_block_out        = security_reg[tile_regs_pkg::SEC_TAP_BIT];
   assign pll_jtag_block_out        = security_reg[tile_regs_pkg::SEC_PLLJTAG_BIT];
   assign global_debug_block_out    = security_reg[tile_regs_pkg::SEC_GDEBUG_BIT];
   assign otp_master_lock_out       = security_reg[tile_regs_pkg::SEC_MASTER_BIT];
   assign otp_sector_lock_out       =
      security_reg[tile_regs_pkg::SEC_SECTOR_MSB:tile_regs_pkg::SEC_SECTOR_LSB];
   assign otp_redundancy_enable_out = security_reg[tile_regs_pkg::SEC_REDUND_BIT];
   assign otp_image_boot_force_out  = security_reg[tile_regs_pkg::SEC_IMAGE_BIT];

   // low power clock divide request
   logic div_active_reg, div_active_next;

   always_comb begin
      div_active_next = feature_reg[tile_regs_pkg::DIV_EN_BIT] &&
                        (!feature_reg[tile_regs_pkg::DYN_MODE_BIT] || threads_paused_in);
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         div_active_reg <= 1'b0;
      end else begin
         div_active_reg <= div_active_next;
      end
   end

   assign pll_divide_active_out = div_active_reg;

   // rgmii tx clock; ref_clk stands for the pll output here
   logic [DIV_W-1:0] div_cnt_reg, div_cnt_next;
   logic             tx_clk_reg,  tx_clk_next;

   always_comb begin
      div_cnt_next = div_cnt_reg;
      tx_clk_next  = tx_clk_reg;
      if (!rgmii_port_enable_out) begin
         div_cnt_next = '0;
         tx_clk_next  = 1'b0;
      end else begin
         div_cnt_next = (div_cnt_reg >= tx_div) ? '0 : DIV_W'(div_cnt_reg + 1'b1);
         // with a divider of zero both match and the clock stays high
         if (div_cnt_reg == tx_div) begin
            tx_clk_next = 1'b1;
         end else if (div_cnt_reg == (tx_div >> 1)) begin
            tx_clk_next = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
         div_cnt_reg <= '0;
         tx_clk_reg  <= 1'b0;
      end else begin
         div_cnt_reg <= div_cnt_next;
         tx_clk_reg  <= tx_clk_next;
      end
   end

   assign rgmii_tx_clk_out = tx_clk_reg;

   // tx data delay line; slots are not reset, stale data drains in delay cycles
   tile_regs_pkg::rgmii_lane_t delay_mem [DELAY_DEPTH];
   tile_regs_pkg::rgmii_lane_t lane_reg, lane_next;
   logic [PTR_W-1:0]           wptr_reg, wptr_next;

   always_comb begin
      wptr_next = PTR_W'(wptr_reg + 1'b1);
      if (tx_delay == 8'h00) begin
         lane_next = tx_lane_in;
      end else begin
         lane_next = delay_mem[PTR_W'(wptr_reg - tx_delay)];
      end
   end

   always_ff @(posedge ref_clk_in) begin
      delay_mem[wptr_reg] <= tx_lane_in;
      if (rst_in) begin
         wptr_reg <= '0;
         lane_reg <= '0;
      end else begin
         wptr_reg <= wptr_next;
         lane_reg <= lane_next;
      end
   end

   assign tx_lane_out = lane_reg;

   // ring oscillators: ticks arrive unrelated to the tile clock
   always_comb begin
      osc_run_next = {{2{osc_ctrl_reg[tile_regs_pkg::OSC_PERIPH_BIT]}},
                      {2{osc_ctrl_reg[tile_regs_pkg::OSC_CORE_BIT]}}};
      for (int i = 0; i < tile_regs_pkg::OSC_NUM; i++) begin
         osc_count_next[i] = osc_count_reg[i];
         if (osc_run_reg[i] && osc_s2_reg[i] && !osc_s3_reg[i]) begin
            osc_count_next[i] = 16'(osc_count_reg[i] + 1'b1);
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      osc_s1_reg <= oscillator_tick_in;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      for (int i = 0; i < tile_regs_pkg::OSC_NUM; i++) begin
         osc_count_reg[i] <= osc_count_next[i];
      end
      if (rst_in) begin
         osc_run_reg <= 4'h0;
      end else begin
         osc_run_reg <= osc_run_next;
      end
   end

   assign oscillator_run_out = osc_run_reg;

   // checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);

   logic feat_wr, sec_wr, osc_wr;
   assign feat_wr = status_write_instr_in && hit(ps_addr_in, tile_regs_pkg::OFS_FEATURE);
   assign sec_wr  = status_write_instr_in && hit(ps_addr_in, tile_regs_pkg::OFS_SECURITY);
   assign osc_wr  = status_write_instr_in && hit(ps_addr_in, tile_regs_pkg::OFS_OSC_CTRL);

   sequence locked_write_s;
      security_reg[tile_regs_pkg::SEC_LOCK_BIT] && sec_wr && !otp_load_in;
   endsequence

   sequence held_delay3_s;
      (tx_delay == 8'h03) [*5];
   endsequence

   AST_TX_DELAY3: assert property (held_delay3_s |-> tx_lane_out == $past(tx_lane_in, 4))
      else $error("tx data not delayed by three slots");
   // the output register was cleared by reset, so the cycle after release is not a pass-through
   AST_TX_DELAY0: assert property (!$past(rst_in) && $past(tx_delay) == 8'h00 |->
                                   tx_lane_out == $past(tx_lane_in))
      else $error("tx data not passed with zero delay");
   AST_TX_CLK_RISE: assert property (rgmii_port_enable_out && div_cnt_reg == tx_div
                                     |=> !rgmii_port_enable_out || rgmii_tx_clk_out)
      else $error("tx clock did not rise at divider value");
   AST_TX_CLK_FALL: assert property (rgmii_port_enable_out && div_cnt_reg != tx_div &&
                                     div_cnt_reg == (tx_div >> 1) |=> !rgmii_tx_clk_out)
      else $error("tx clock did not fall at half divider value");
   AST_RGMII_EN: assert property (feat_wr |=> rgmii_port_enable_out == $past(ps_wdata_in[8]))
      else $error("rgmii port enable not written");
   AST_DYN_HOLD: assert property (div_active_next && feature_reg[tile_regs_pkg::DYN_MODE_BIT]
                                  |-> threads_paused_in ##1 pll_divide_active_out)
      else $error("dynamic divide acted while threads ran");
   AST_STATIC_DIV: assert property ((feature_reg[tile_regs_pkg::DIV_EN_BIT] &&
                                     !feature_reg[tile_regs_pkg::DYN_MODE_BIT]) [*2]
                                    |-> pll_divide_active_out)
      else $error("static divide not active");
   AST_USB_MODE: assert property (feat_wr |=> usb_utmi_mode_out == $past(ps_wdata_in[2]) &&
                                  ulpi_support_enable_out == $past(ps_wdata_in[1]))
      else $error("usb mode bits not written");
   AST_BOOT_READ: assert property (status_read_instr_in &&
                                   hit(ps_addr_in, tile_regs_pkg::OFS_BOOT) |=> ps_rvalid_out &&
                                   ps_rdata_out[23:16] == $past(processor_number_in) &&
                                   ps_rdata_out[31:24] == 8'h00 && ps_rdata_out[1:0] ==
                                   boot_reg.pll_mode_pin_sample)
      else $error("boot state read wrong");
   AST_SEC_LOAD: assert property (otp_load_in |=> jtag_tap_block_out == $past(otp_word_in[0]) &&
                                  otp_sector_lock_out == $past(otp_word_in[11:8]) &&
                                  global_debug_block_out == $past(otp_word_in[14]))
      else $error("otp security word not copied");
   AST_SEC_LOCK: assert property (locked_write_s |=> $stable(security_reg))
      else $error("locked security register was written");
   AST_SEC_STAYS: assert property (security_reg[tile_regs_pkg::SEC_LOCK_BIT] &&
                                   !otp_load_in |=> security_reg[tile_regs_pkg::SEC_LOCK_BIT])
      else $error("security lock cleared without reset");
   AST_OSC_RUN: assert property (osc_wr |=> ##1 oscillator_run_out ==
                                 {{2{$past(ps_wdata_in[0], 2)}}, {2{$past(ps_wdata_in[1], 2)}}})
      else $error("oscillator enables not applied");
   AST_OSC_STOP: assert property (!osc_run_reg[0] |=> osc_count_reg[0] == $past(osc_count_reg[0]))
      else $error("stopped oscillator counter moved");
   AST_OSC_READ: assert property (status_read_instr_in && ps_addr_in == 8'h09 |=>
                                  ps_rdata_out == {16'h0000, $past(osc_count_reg[2])})
      else $error("oscillator count read wrong");

endmodule

// ===== tile_control_status_regs_bench.sv
// self-checking bench of the tile control and status bank
`timescale 1ns/1ps
module tile_control_status_regs_bench;
   logic ref_clk_in = 1'b0, rst_in = 1'b1, status_write_instr_in = 1'b0;
   logic status_read_instr_in = 1'b0, otp_load_in = 1'b0, threads_paused_in = 1'b0;
   logic ps_rvalid_out, rgmii_tx_clk_out, rgmii_port_enable_out, pll_divide_active_out;
   logic usb_utmi_mode_out, ulpi_support_enable_out, jtag_tap_block_out, pll_jtag_block_out;
   logic global_debug_block_out, otp_master_lock_out, otp_redundancy_enable_out;
   logic otp_image_boot_force_out, prev;
   logic [7:0]  ps_addr_in = 8'h00, processor_number_in = 8'hc3;
   logic [31:0] ps_wdata_in = 32'h0, otp_word_in = 32'h0, ps_rdata_out, d, base;
   logic [3:0]  otp_sector_lock_out, oscillator_tick_in = 4'h0, oscillator_run_out;
   tile_regs_pkg::boot_straps_t straps_in = 7'h56;
   tile_regs_pkg::rgmii_lane_t  tx_lane_in = 5'h00, tx_lane_out;
   int n_mismatch = 0, compares = 0, cyc = 0, hi, rises;
   tile_control_status_regs dut_u (.ref_clk_in, .rst_in, .status_write_instr_in,
      .status_read_instr_in, .ps_addr_in, .ps_wdata_in, .ps_rdata_out, .ps_rvalid_out,
      .processor_number_in, .straps_in, .otp_load_in, .otp_word_in, .threads_paused_in,
      .tx_lane_in, .tx_lane_out, .rgmii_tx_clk_out, .rgmii_port_enable_out,
      .pll_divide_active_out, .usb_utmi_mode_out, .ulpi_support_enable_out,
      .jtag_tap_block_out, .pll_jtag_block_out, .global_debug_block_out, .otp_master_lock_out,
      .otp_sector_lock_out, .otp_redundancy_enable_out, .otp_image_boot_force_out,
      .oscillator_tick_in, .oscillator_run_out);
   always #5 ref_clk_in = ~ref_clk_in;
   // hang guard, well past the roughly 170 cycles the tests need
   always @(posedge ref_clk_in) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(negedge ref_clk_in);
      {status_write_instr_in, ps_addr_in, ps_wdata_in} = {1'b1, a, v};
      @(negedge ref_clk_in);
      status_write_instr_in = 1'b0;
   endtask
   // rvalid and data stand for one cycle only, so they are sampled right then
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(negedge ref_clk_in);
      {status_read_instr_in, ps_addr_in} = {1'b1, a};
      @(negedge ref_clk_in);
      status_read_instr_in = 1'b0;
      check({31'h0, ps_rvalid_out}, 32'h1);
      v = ps_rdata_out;
   endtask
   task automatic t_feature();
      rd(8'h02, d); check(d, 32'h0);
      wr(8'h02, 32'hffff_ffff); rd(8'h02, d); check(d, 32'h03ff_ff36);
      check({rgmii_port_enable_out, usb_utmi_mode_out, ulpi_support_enable_out}, 7);
      wr(8'h02, 32'h0000_0002); @(negedge ref_clk_in);
      check({usb_utmi_mode_out, ulpi_support_enable_out, rgmii_port_enable_out}, 2);
      rd(8'h0b, d); check(d, 32'h0);
      $display("feature test done");
   endtask
   task automatic t_boot();
      wr(8'h03, 32'hffff_ffff); rd(8'h03, d); check(d, 32'h00c3_0116);
      processor_number_in = 8'h3c; rd(8'h03, d); check(d, 32'h003c_0116);
      $display("boot test done");
   endtask
   task automatic t_security();
      rd(8'h05, d); check(d, 32'h0);
      wr(8'h05, 32'h0000_5fb1); rd(8'h05, d); check(d, 32'h0000_5fb1);
      check({global_debug_block_out, pll_jtag_block_out, jtag_tap_block_out, otp_master_lock_out,
         otp_sector_lock_out, otp_redundancy_enable_out, otp_image_boot_force_out}, 10'h3ff);
      wr(8'h05, 32'h8000_0000); wr(8'h05, 32'h0000_0001);
      rd(8'h05, d); check(d, 32'h8000_0000);
      check({31'h0, jtag_tap_block_out}, 32'h0);
      otp_word_in = 32'hffff_ffff;
      @(negedge ref_clk_in) otp_load_in = 1'b1;
      @(negedge ref_clk_in) otp_load_in = 1'b0;
      rd(8'h05, d); check(d, 32'h8000_5fb1);
      $display("security test done");
   endtask
   // three extra slots of delay give four cycles from input to output
   task automatic t_delay();
      wr(8'h02, 32'h000c_0000);
      for (int i = 0; i < 16; i++) begin
         @(negedge ref_clk_in);
         if (i >= 5) check({27'h0, tx_lane_out}, i - 4);
         tx_lane_in = 5'(i);
      end
      $display("delay test done");
   endtask
   task automatic t_txclk();
      // ratio four is written as field three
      wr(8'h02, 32'h0000_0700);
      repeat (8) @(negedge ref_clk_in);
      hi = 0; rises = 0;
      prev = rgmii_tx_clk_out;
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk_in);
         hi += int'(rgmii_tx_clk_out === 1'b1);
         rises += int'(rgmii_tx_clk_out === 1'b1 && prev === 1'b0);
         prev = rgmii_tx_clk_out;
      end
      check({16'(hi), 16'(rises)}, {16'd20, 16'd10});
      $display("tx clock test done");
   endtask
   task automatic t_divide();
      wr(8'h02, 32'h0000_0030); repeat (2) @(negedge ref_clk_in);
      check({31'h0, pll_divide_active_out}, 32'h0);
      threads_paused_in = 1'b1; repeat (2) @(negedge ref_clk_in);
      check({31'h0, pll_divide_active_out}, 32'h1);
      threads_paused_in = 1'b0; wr(8'h02, 32'h0000_0010); repeat (2) @(negedge ref_clk_in);
      check({31'h0, pll_divide_active_out}, 32'h1);
      $display("divide test done");
   endtask
   task automatic t_osc();
      rd(8'h07, base);
      wr(8'h06, 32'h0000_0002); @(negedge ref_clk_in);
      check({28'h0, oscillator_run_out}, 32'h3);
      repeat (5) begin
         repeat (2) @(negedge ref_clk_in) oscillator_tick_in[0] = ~oscillator_tick_in[0];
         repeat (2) @(negedge ref_clk_in);
      end
      wr(8'h06, 32'h0000_0000); repeat (12) @(negedge ref_clk_in);
      rd(8'h07, d); check(d, {16'h0, base[15:0] + 16'h5});
      rd(8'h08, d); check(d & 32'hffff_0000, 32'h0);
      rd(8'h09, d); check(d, 32'h0);
      rst_in = 1'b1; repeat (4) @(negedge ref_clk_in); rst_in = 1'b0;
      rd(8'h07, d); check(d, {16'h0, base[15:0] + 16'h5});
      rd(8'h06, d); check(d, 32'h0);
      $display("oscillator test done");
   endtask
   task automatic complete_run();
      $display("mismatches %0d of %0d compares", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge ref_clk_in);
      rst_in = 1'b0;
      t_feature(); t_boot(); t_security(); t_delay(); t_txclk(); t_divide(); t_osc();
      complete_run();
   end
endmodule
